// [hw/ccrb_bank.sv]
`timescale 1ns/1ps

module ccrb_bank #(
  parameter int unsigned SETTLE_LONG  = ccrb_pkg::SETTLE_LONG_CYC,
  parameter int unsigned SETTLE_SHORT = ccrb_pkg::SETTLE_SHORT_CYC,
  parameter int unsigned RUN_CYC      = ccrb_pkg::CAL_RUN_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  output logic [7:0]      rd_data_o,
  input  wire logic [3:0] meas_mon_first_i,
  input  wire logic [3:0] meas_mon_second_i,
  input  wire logic [7:0] meas_dac_ofs_i,
  input  wire logic [1:0] meas_adc_ofs_i,
  input  wire logic [5:0] meas_balance_i,
  output logic [4:0]      ring_mismatch_value_o,
  output logic [4:0]      tip_mismatch_value_o,
  output logic [4:0]      differential_gain_value_o,
  output logic [4:0]      common_gain_value_o,
  output logic [3:0]      current_limit_value_o,
  output logic [3:0]      monitor_offset_first_o,
  output logic [3:0]      monitor_offset_second_o,
  output logic            dac_offset_positive_o,
  output logic            dac_offset_negative_o,
  output logic            adc_offset_positive_o,
  output logic            adc_offset_negative_o,
  output logic [7:0]      dac_offset_value_o,
  output logic [5:0]      balance_value_o,
  output logic [3:0]      peak_monitor_value_o,
  output logic            settle_active_o,
  output logic            settling_speedup_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  typedef enum logic [1:0] {SYS_IDLE, SYS_SETTLE, SYS_CAL} ccrb_sys_st_t;

  localparam int unsigned CW = ccrb_pkg::SETTLE_CW;

  logic [4:0]    ring_q;
  logic [4:0]    tip_q;
  logic [4:0]    diff_q;
  logic [4:0]    cm_q;
  logic [3:0]    ilim_q;
  logic [7:0]    mon_q;
  logic [3:0]    steer_q;
  logic [7:0]    dac_q;
  logic [5:0]    bal_q;
  logic [3:0]    peak_q;
  logic          speedup_q;
  logic [7:0]    rd_data_q;
  ccrb_sys_st_t  sys_q;
  logic [CW-1:0] settle_cnt_q;
  logic          sys_launch;
  logic          sys_busy;
  logic          ctrl_wr;
  logic [4:0]    eng_start;
  logic [4:0]    eng_disarm;
  logic [4:0]    eng_busy;
  logic [4:0]    eng_load;
  logic [3:0]    val_m1;
  logic [3:0]    val_m2;
  logic [7:0]    val_dac;
  logic [1:0]    val_adc;
  logic [5:0]    val_bal;

  // True for a software write at the given offset.
  function automatic logic wr_at(input logic [7:0] a);
    return wr_en_i && (addr_i == a);
  endfunction : wr_at

  //////////////////////////////////////////////////////////////////////////////
  // Calibration channels.

  // A one written to a control bit starts its channel, a zero disarms it.
  // The decode is spelled out so that these nets follow the strobe itself.
  assign ctrl_wr    = wr_en_i && (addr_i == ccrb_pkg::ADDR_CAL_CTRL_TWO);
  assign eng_start  = ({5{ctrl_wr}} & wr_data_i[4:0])
                    | {5{sys_launch}};
  assign eng_disarm = {5{ctrl_wr}} & ~wr_data_i[4:0];

  // Two separate monitor converter channels.
  ccrb_cal_engine #(.W(4), .RUN_CYC(RUN_CYC)) u_eng_m1 (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .armed_rst_i (ccrb_pkg::RST_CAL_CTRL_TWO[ccrb_pkg::BIT_MON_FIRST]),
    .start_i     (eng_start[ccrb_pkg::BIT_MON_FIRST]),
    .disarm_i    (eng_disarm[ccrb_pkg::BIT_MON_FIRST]),
    .meas_i      (meas_mon_first_i),
    .busy_o      (eng_busy[ccrb_pkg::BIT_MON_FIRST]),
    .load_o      (eng_load[ccrb_pkg::BIT_MON_FIRST]),
    .value_o     (val_m1)
  );

  ccrb_cal_engine #(.W(4), .RUN_CYC(RUN_CYC)) u_eng_m2 (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .armed_rst_i (ccrb_pkg::RST_CAL_CTRL_TWO[ccrb_pkg::BIT_MON_SECOND]),
    .start_i     (eng_start[ccrb_pkg::BIT_MON_SECOND]),
    .disarm_i    (eng_disarm[ccrb_pkg::BIT_MON_SECOND]),
    .meas_i      (meas_mon_second_i),
    .busy_o      (eng_busy[ccrb_pkg::BIT_MON_SECOND]),
    .load_o      (eng_load[ccrb_pkg::BIT_MON_SECOND]),
    .value_o     (val_m2)
  );

  // Audio DAC offset channel.
  ccrb_cal_engine #(.W(8), .RUN_CYC(RUN_CYC)) u_eng_dac (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .armed_rst_i (ccrb_pkg::RST_CAL_CTRL_TWO[ccrb_pkg::BIT_DAC]),
    .start_i     (eng_start[ccrb_pkg::BIT_DAC]),
    .disarm_i    (eng_disarm[ccrb_pkg::BIT_DAC]),
    .meas_i      (meas_dac_ofs_i),
    .busy_o      (eng_busy[ccrb_pkg::BIT_DAC]),
    .load_o      (eng_load[ccrb_pkg::BIT_DAC]),
    .value_o     (val_dac)
  );

  // Audio ADC offset channel, result lands in the steering bits.
  ccrb_cal_engine #(.W(2), .RUN_CYC(RUN_CYC)) u_eng_adc (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .armed_rst_i (ccrb_pkg::RST_CAL_CTRL_TWO[ccrb_pkg::BIT_ADC]),
    .start_i     (eng_start[ccrb_pkg::BIT_ADC]),
    .disarm_i    (eng_disarm[ccrb_pkg::BIT_ADC]),
    .meas_i      (meas_adc_ofs_i),
    .busy_o      (eng_busy[ccrb_pkg::BIT_ADC]),
    .load_o      (eng_load[ccrb_pkg::BIT_ADC]),
    .value_o     (val_adc)
  );

  // Longitudinal balance channel.
  ccrb_cal_engine #(.W(6), .RUN_CYC(RUN_CYC)) u_eng_bal (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .armed_rst_i (ccrb_pkg::RST_CAL_CTRL_TWO[ccrb_pkg::BIT_BAL]),
    .start_i     (eng_start[ccrb_pkg::BIT_BAL]),
    .disarm_i    (eng_disarm[ccrb_pkg::BIT_BAL]),
    .meas_i      (meas_balance_i),
    .busy_o      (eng_busy[ccrb_pkg::BIT_BAL]),
    .load_o      (eng_load[ccrb_pkg::BIT_BAL]),
    .value_o     (val_bal)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Whole-system calibration sequencer.

  // Settling first, then every channel at once, then wait for all to finish.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sys_q        <= SYS_IDLE;
      settle_cnt_q <= '0;
    end else begin
      case (sys_q)
        SYS_IDLE: begin
          if (wr_at(ccrb_pkg::ADDR_SYS_CAL) && wr_data_i[ccrb_pkg::BIT_SYS_RUN]) begin
            sys_q        <= SYS_SETTLE;
            // A speedup written together with the run bit applies to this run.
            settle_cnt_q <= wr_data_i[ccrb_pkg::BIT_SYS_SPEEDUP] ? CW'(SETTLE_SHORT - 1)
                                                                 : CW'(SETTLE_LONG - 1);
          end
        end
        SYS_SETTLE: begin
          if (settle_cnt_q == '0) begin
            sys_q <= SYS_CAL;
          end else begin
            settle_cnt_q <= settle_cnt_q - CW'(1);
          end
        end
        SYS_CAL: begin
          if (eng_busy == 5'h00) begin
            sys_q <= SYS_IDLE;
          end
        end
        default: sys_q <= SYS_IDLE;
      endcase
    end
  end

  assign sys_launch      = (sys_q == SYS_SETTLE) && (settle_cnt_q == '0);
  assign sys_busy        = (sys_q != SYS_IDLE);
  assign settle_active_o = (sys_q == SYS_SETTLE);

  // Speedup setting.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      speedup_q <= 1'b0;
    end else if (wr_at(ccrb_pkg::ADDR_SYS_CAL)) begin
      speedup_q <= wr_data_i[ccrb_pkg::BIT_SYS_SPEEDUP];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result registers; a channel load wins over a software write.

  // Trims that only software sets.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ring_q <= ccrb_pkg::RST_RING_GM;
      tip_q  <= ccrb_pkg::RST_TIP_GM;
      diff_q <= ccrb_pkg::RST_DIFF_GAIN;
      cm_q   <= ccrb_pkg::RST_CM_GAIN;
      ilim_q <= ccrb_pkg::RST_ILIM;
      peak_q <= ccrb_pkg::RST_PEAK_MON;
    end else begin
      if (wr_at(ccrb_pkg::ADDR_RING_GM)) begin
        ring_q <= wr_data_i[4:0];
      end
      if (wr_at(ccrb_pkg::ADDR_TIP_GM)) begin
        tip_q <= wr_data_i[4:0];
      end
      if (wr_at(ccrb_pkg::ADDR_DIFF_GAIN)) begin
        diff_q <= wr_data_i[4:0];
      end
      if (wr_at(ccrb_pkg::ADDR_CM_GAIN)) begin
        cm_q <= wr_data_i[4:0];
      end
      if (wr_at(ccrb_pkg::ADDR_ILIM)) begin
        ilim_q <= wr_data_i[3:0];
      end
      if (wr_at(ccrb_pkg::ADDR_PEAK_MON)) begin
        peak_q <= wr_data_i[3:0];
      end
    end
  end

  // Monitor converter offsets, one nibble per channel.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mon_q <= ccrb_pkg::RST_MON_OFS;
    end else begin
      if (wr_at(ccrb_pkg::ADDR_MON_OFS)) begin
        mon_q <= wr_data_i;
      end
      if (eng_load[ccrb_pkg::BIT_MON_FIRST]) begin
        mon_q[7:4] <= val_m1;
      end
      if (eng_load[ccrb_pkg::BIT_MON_SECOND]) begin
        mon_q[3:0] <= val_m2;
      end
    end
  end

  // Offset steering, DAC offset and balance results.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      steer_q <= ccrb_pkg::RST_OFS_STEER;
      dac_q   <= ccrb_pkg::RST_DAC_OFS;
      bal_q   <= ccrb_pkg::RST_BALANCE;
    end else begin
      if (wr_at(ccrb_pkg::ADDR_OFS_STEER)) begin
        steer_q <= wr_data_i[3:0];
      end
      if (eng_load[ccrb_pkg::BIT_ADC]) begin
        steer_q[1:0] <= val_adc;
      end
      if (wr_at(ccrb_pkg::ADDR_DAC_OFS)) begin
        dac_q <= wr_data_i;
      end
      if (eng_load[ccrb_pkg::BIT_DAC]) begin
        dac_q <= val_dac;
      end
      if (wr_at(ccrb_pkg::ADDR_BALANCE)) begin
        bal_q <= wr_data_i[5:0];
      end
      if (eng_load[ccrb_pkg::BIT_BAL]) begin
        bal_q <= val_bal;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port; data stand one cycle after the strobe, zero otherwise.

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rd_en_i) begin
      rd_data_q <= 8'h00;
    end else begin
      case (addr_i)
        ccrb_pkg::ADDR_CAL_CTRL_TWO: rd_data_q <= {3'h0, eng_busy};
        ccrb_pkg::ADDR_RING_GM:      rd_data_q <= {3'h0, ring_q};
        ccrb_pkg::ADDR_TIP_GM:       rd_data_q <= {3'h0, tip_q};
        ccrb_pkg::ADDR_DIFF_GAIN:    rd_data_q <= {3'h0, diff_q};
        ccrb_pkg::ADDR_CM_GAIN:      rd_data_q <= {3'h0, cm_q};
        ccrb_pkg::ADDR_ILIM:         rd_data_q <= {4'h0, ilim_q};
        ccrb_pkg::ADDR_MON_OFS:      rd_data_q <= mon_q;
        ccrb_pkg::ADDR_OFS_STEER:    rd_data_q <= {4'h0, steer_q};
        ccrb_pkg::ADDR_DAC_OFS:      rd_data_q <= dac_q;
        ccrb_pkg::ADDR_BALANCE:      rd_data_q <= {2'h0, bal_q};
        ccrb_pkg::ADDR_PEAK_MON:     rd_data_q <= {4'h0, peak_q};
        ccrb_pkg::ADDR_SYS_CAL:      rd_data_q <= {6'h00, sys_busy, speedup_q};
        default:                     rd_data_q <= 8'h00;
      endcase
    end
  end

  assign rd_data_o = rd_data_q;

  // Trim outputs straight from the result registers.
  assign ring_mismatch_value_o     = ring_q;
  assign tip_mismatch_value_o      = tip_q;
  assign differential_gain_value_o = diff_q;
  assign common_gain_value_o       = cm_q;
  assign current_limit_value_o     = ilim_q;
  assign monitor_offset_first_o    = mon_q[7:4];
  assign monitor_offset_second_o   = mon_q[3:0];
  assign dac_offset_positive_o     = steer_q[3];
  assign dac_offset_negative_o     = steer_q[2];
  assign adc_offset_positive_o     = steer_q[1];
  assign adc_offset_negative_o     = steer_q[0];
  assign dac_offset_value_o        = dac_q;
  assign balance_value_o           = bal_q;
  assign peak_monitor_value_o      = peak_q;
  assign settling_speedup_o        = speedup_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_go(int b);
    wr_en_i && (addr_i == ccrb_pkg::ADDR_CAL_CTRL_TWO) && wr_data_i[b];
  endsequence

  sequence s_rd(logic [7:0] a);
    rd_en_i && (addr_i == a);
  endsequence

  AST_DAC_START: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_go(2) |=> eng_busy[2] [*2])
    else $error("DAC offset control bit not busy after start.");

  AST_ADC_START: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_go(1) |=> eng_busy[1] [*2])
    else $error("ADC offset control bit not busy after start.");

  AST_BAL_START: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_go(0) |=> eng_busy[0] [*2])
    else $error("Balance control bit not busy after start.");

  AST_CTRL_READ: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_rd(ccrb_pkg::ADDR_CAL_CTRL_TWO) |=> rd_data_o == {3'h0, $past(eng_busy)})
    else $error("Control readback differs from channel state.");

  AST_DONE_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_go(2) ##1 eng_busy[2] [*1] |-> ##[1:300] !eng_busy[2])
    else $error("DAC offset control bit did not clear after the run.");

  AST_RING_READ: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_rd(ccrb_pkg::ADDR_RING_GM) |=> rd_data_o == {3'h0, $past(ring_q)})
    else $error("Ring mismatch readback wrong.");

  AST_BAL_READ: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    s_rd(ccrb_pkg::ADDR_BALANCE) |=> rd_data_o == {2'h0, $past(bal_q)})
    else $error("Balance readback wrong.");

  AST_SYS_BUSY: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    (sys_q == SYS_IDLE) && wr_en_i && (addr_i == ccrb_pkg::ADDR_SYS_CAL) && wr_data_i[1]
    |=> sys_busy [*2])
    else $error("System calibration not busy after start.");

  AST_SETTLE_LEN: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    (sys_q == SYS_IDLE) && wr_en_i && (addr_i == ccrb_pkg::ADDR_SYS_CAL) && wr_data_i[1]
    |=> settle_cnt_q == ($past(wr_data_i[ccrb_pkg::BIT_SYS_SPEEDUP]) ? CW'(SETTLE_SHORT - 1)
                                                                      : CW'(SETTLE_LONG - 1)))
    else $error("Settling count does not follow the speedup setting.");

  AST_RESULT_FIRST: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    eng_load[2] |-> eng_busy[2] ##1 (dac_q == $past(val_dac)) && !eng_busy[2])
    else $error("DAC result not stored while control bit still set.");

  AST_SW_KEEP: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    wr_en_i && (addr_i == ccrb_pkg::ADDR_DAC_OFS) && !eng_load[2] |=> dac_q == $past(wr_data_i))
    else $error("Software DAC offset write not kept.");

endmodule : ccrb_bank

// [hw/ccrb_cal_engine.sv]
`timescale 1ns/1ps

// One calibration channel: armed after reset, runs on start, loads a result.
module ccrb_cal_engine #(
  parameter int unsigned W       = 8,
  parameter int unsigned RUN_CYC = ccrb_pkg::CAL_RUN_CYC
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         armed_rst_i,
  input  wire logic         start_i,
  input  wire logic         disarm_i,
  input  wire logic [W-1:0] meas_i,
  output logic              busy_o,
  output logic              load_o,
  output logic [W-1:0]      value_o
);

  typedef enum logic [1:0] {ST_ARMED, ST_RUN, ST_LOAD, ST_IDLE} ccrb_eng_st_t;

  ccrb_eng_st_t state_q;
  logic [15:0]  cnt_q;
  logic         last_run;

  // The run ends on the last counted cycle of the measurement.
  assign last_run = (state_q == ST_RUN) && (cnt_q == 16'(RUN_CYC - 1));

  // Channel sequence; a start during a run is ignored.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= ST_ARMED;
      if (!armed_rst_i) begin
        state_q <= ST_IDLE;
      end
    end else begin
      case (state_q)
        ST_ARMED: begin
          if (start_i) begin
            state_q <= ST_RUN;
          end else if (disarm_i) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RUN: begin
          if (last_run) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: state_q <= ST_IDLE;
        ST_IDLE: begin
          if (start_i) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_ARMED;
      endcase
    end
  end

  // Run length counter.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_q != ST_RUN) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Result is captured at the end of the run and offered during load.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      value_o <= '0;
    end else if (last_run) begin
      value_o <= meas_i;
    end
  end

  // Busy covers the armed, running and loading states.
  assign busy_o = (state_q != ST_IDLE);
  assign load_o = (state_q == ST_LOAD);

endmodule : ccrb_cal_engine

// [include/ccrb_pkg.sv]
package ccrb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing.

  // System clock rate in kHz, 25 MHz.
  localparam int unsigned CLK_KHZ          = 25000;
  // Battery settling time at the start of a system calibration, in ms.
  localparam int unsigned SETTLE_LONG_MS   = 300;
  localparam int unsigned SETTLE_SHORT_MS  = 30;
  localparam int unsigned SETTLE_LONG_CYC  = SETTLE_LONG_MS * CLK_KHZ;
  localparam int unsigned SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CLK_KHZ;
  // Width of the settling counter, enough for the long count.
  localparam int unsigned SETTLE_CW        = 23;
  // Length of one single calibration run in cycles.
  localparam int unsigned CAL_RUN_CYC      = 64;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets.

  localparam logic [7:0] ADDR_CAL_CTRL_TWO = 8'h61;
  localparam logic [7:0] ADDR_RING_GM      = 8'h62;
  localparam logic [7:0] ADDR_TIP_GM       = 8'h63;
  localparam logic [7:0] ADDR_DIFF_GAIN    = 8'h64;
  localparam logic [7:0] ADDR_CM_GAIN      = 8'h65;
  localparam logic [7:0] ADDR_ILIM         = 8'h66;
  localparam logic [7:0] ADDR_MON_OFS      = 8'h67;
  localparam logic [7:0] ADDR_OFS_STEER    = 8'h68;
  localparam logic [7:0] ADDR_DAC_OFS      = 8'h69;
  localparam logic [7:0] ADDR_BALANCE      = 8'h6a;
  localparam logic [7:0] ADDR_PEAK_MON     = 8'h6b;
  localparam logic [7:0] ADDR_SYS_CAL      = 8'h6f;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.

  localparam logic [4:0] RST_CAL_CTRL_TWO  = 5'h1f;
  localparam logic [4:0] RST_RING_GM       = 5'h10;
  localparam logic [4:0] RST_TIP_GM        = 5'h10;
  localparam logic [4:0] RST_DIFF_GAIN     = 5'h11;
  localparam logic [4:0] RST_CM_GAIN       = 5'h11;
  localparam logic [3:0] RST_ILIM          = 4'h8;
  localparam logic [7:0] RST_MON_OFS       = 8'h88;
  localparam logic [3:0] RST_OFS_STEER     = 4'h0;
  localparam logic [7:0] RST_DAC_OFS       = 8'h00;
  localparam logic [5:0] RST_BALANCE       = 6'h20;
  localparam logic [3:0] RST_PEAK_MON      = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.

  localparam int unsigned BIT_MON_FIRST    = 4;
  localparam int unsigned BIT_MON_SECOND   = 3;
  localparam int unsigned BIT_DAC          = 2;
  localparam int unsigned BIT_ADC          = 1;
  localparam int unsigned BIT_BAL          = 0;
  localparam int unsigned BIT_SYS_RUN      = 1;
  localparam int unsigned BIT_SYS_SPEEDUP  = 0;

endpackage : ccrb_pkg

// [verif/ccrb_bank_bench.sv]
`timescale 1ns/1ps

module ccrb_bank_bench;
  logic       clk   = 1'b0;
  logic       srst  = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdat  = 8'h00;
  logic       wen   = 1'b0;
  logic       ren   = 1'b0;
  logic [3:0] m1    = 4'h3;
  logic [3:0] m2    = 4'hc;
  logic [7:0] md    = 8'h5a;
  logic [1:0] ma    = 2'h2;
  logic [5:0] mb    = 6'h15;
  logic [7:0] rdat;
  logic [7:0] dov;
  logic [3:0] mof;
  logic [3:0] mos;
  logic [5:0] bal;
  logic [4:0] rgo, tpo, dfo, cmo;
  logic [3:0] ilo, pko;
  logic       dp, dn, ap, an, st, sp;
  int         num_errors = 0;
  int         tests_run  = 0;
  int         cyc        = 0;
  logic [7:0] rv [11] = '{8'h1f, 8'h10, 8'h10, 8'h11, 8'h11, 8'h08, 8'h88, 8'h00, 8'h00,
                          8'h20, 8'h08};
  logic [7:0] mk [11] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h0f, 8'hff, 8'h0f, 8'hff,
                          8'h3f, 8'h0f};

  // Short settling and run counts keep the system calibration brief.
  ccrb_bank #(.SETTLE_LONG(20), .SETTLE_SHORT(5), .RUN_CYC(4)) dut (
    .core_clk_i(clk), .srst_i(srst), .addr_i(addr), .wr_data_i(wdat), .wr_en_i(wen),
    .rd_en_i(ren), .rd_data_o(rdat), .meas_mon_first_i(m1), .meas_mon_second_i(m2),
    .meas_dac_ofs_i(md), .meas_adc_ofs_i(ma), .meas_balance_i(mb),
    .ring_mismatch_value_o(rgo), .tip_mismatch_value_o(tpo), .differential_gain_value_o(dfo),
    .common_gain_value_o(cmo), .current_limit_value_o(ilo), .monitor_offset_first_o(mof),
    .monitor_offset_second_o(mos), .dac_offset_positive_o(dp), .dac_offset_negative_o(dn),
    .adc_offset_positive_o(ap), .adc_offset_negative_o(an), .dac_offset_value_o(dov),
    .balance_value_o(bal), .peak_monitor_value_o(pko), .settle_active_o(st),
    .settling_speedup_o(sp));

  // Clock and hang guard.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus and compare helpers.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wen  <= 1'b1;
    @(posedge clk);
    wen  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    ren  <= 1'b1;
    @(posedge clk);
    ren  <= 1'b0;
    #1 d = rdat;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    for (int i = 0; i < 11; i++) rc(8'h61 + 8'(i), rv[i]);
    rc(8'h60, 8'h00);
    chk({mof, mos}, 8'h88);
  endtask : t_reset

  task automatic t_rw(input logic [7:0] p);
    for (int i = 1; i < 11; i++) wr(8'h61 + 8'(i), p);
    wr(8'h70, 8'hff);
    for (int i = 1; i < 11; i++) rc(8'h61 + 8'(i), p & mk[i]);
    chk({mof, mos}, p);
    chk({4'h0, dp, dn, ap, an}, p & 8'h0f);
    chk(dov, p);
    chk({2'h0, bal}, p & 8'h3f);
    chk({3'h0, rgo}, p & 8'h1f);
    chk({3'h0, tpo}, p & 8'h1f);
    chk({3'h0, dfo}, p & 8'h1f);
    chk({3'h0, cmo}, p & 8'h1f);
    chk({4'h0, ilo}, p & 8'h0f);
    chk({4'h0, pko}, p & 8'h0f);
  endtask : t_rw

  task automatic t_chan();
    logic [7:0] v;
    int         n;
    wr(8'h61, 8'h00);
    rc(8'h61, 8'h00);
    for (int b = 4; b >= 0; b--) begin
      wr(8'h61, 8'h01 << b);
      rc(8'h61, 8'h01 << b);
      n = 0;
      do begin
        rd(8'h61, v);
        n++;
      end while (v !== 8'h00 && n < 20);
      chk(v, 8'h00);
      // The result must already be in place once the bit reads clear.
      case (b)
        4: begin rd(8'h67, v); chk(v & 8'hf0, {m1, 4'h0}); end
        3: begin rd(8'h67, v); chk(v & 8'h0f, {4'h0, m2}); end
        2: rc(8'h69, md);
        1: begin rd(8'h68, v); chk(v & 8'h03, {6'h0, ma}); end
        default: rc(8'h6a, {2'h0, mb});
      endcase
    end
  endtask : t_chan

  task automatic t_sys(input logic s, input int len);
    logic [7:0] v;
    int         n;
    wr(8'h6f, {6'h00, 1'b1, s});
    n = 0;
    #1;
    while (st !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    while (st === 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n), 8'(len));
    chk({7'h0, sp}, {7'h0, s});
    do rd(8'h6f, v); while (v[1] === 1'b1 && n++ < 150);
    chk(v & 8'h02, 8'h00);
    rc(8'h61, 8'h00);
    chk(dov, md);
  endtask : t_sys

  //////////////////////////////////////////////////////////////////////////////
  // Closing report and main sequence.
  task automatic final_report();
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_rw(8'ha5);
    t_rw(8'h5a);
    t_chan();
    @(posedge clk);
    md <= 8'hc3;
    t_sys(1'b1, 5);
    @(posedge clk);
    md <= 8'h3c;
    t_sys(1'b0, 20);
    // A reset after the runs have finished must bring every written trim back to its default.
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    final_report();
  end
endmodule : ccrb_bank_bench
